// >>> ccpu_capture.sv
`timescale 1ns/1ps
// ==================================================================
// one capture input: edge select, optional noise filter, event counter
module ccpu_capture (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cap_pin,
  input  wire ccpu_pkg::ccpu_cap_cfg_t cfg,
  output logic                         event_p
);

  logic [3:0] hist_r;
  logic       level_r;
  logic       level_d_r;
  logic [3:0] evt_cnt_r;
  logic       edge_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_r <= 4'h0;
    end else begin
      hist_r <= {hist_r[2:0], cap_pin};
    end
  end

  // filtered level only moves after four equal samples
  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (!cfg.filter) begin
      level_r <= cap_pin;
    end else if (hist_r == ccpu_pkg::FILT_ALL_HIGH) begin
      level_r <= 1'b1;
    end else if (hist_r == ccpu_pkg::FILT_ALL_LOW) begin
      level_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_d_r <= 1'b0;
    end else begin
      level_d_r <= level_r;
    end
  end

  assign edge_hit = cfg.rising ? (level_r & ~level_d_r) : (~level_r & level_d_r);

  // events = n lets n edges pass before the one that captures
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_cnt_r <= 4'h0;
      event_p   <= 1'b0;
    end else begin
      event_p <= 1'b0;
      if (edge_hit) begin
        if (evt_cnt_r >= cfg.events) begin
          evt_cnt_r <= 4'h0;
          event_p   <= 1'b1;
        end else begin
          evt_cnt_r <= evt_cnt_r + 4'h1;
        end
      end
    end
  end

endmodule

// >>> ccpu_pins_model.sv
`timescale 1ns/1ps
// ==================================================================
// far side: capture sources and the loads on the compare pins
module ccpu_pins_model (
  input  wire logic       clk,
  input  wire logic [1:0] lvl,
  input  wire logic [3:0] cmp_out,
  input  wire logic [3:0] cmp_oe_n,
  output logic [1:0]      cap_in,
  output logic [3:0]      pin_seen
);
  // sources switch just after the edge, as a clocked driver would
  always @(posedge clk) cap_in <= lvl;
  // an undriven compare pin sits at the board pull-down
  assign pin_seen = cmp_out & ~cmp_oe_n;
endmodule

// >>> ccpu_pkg.sv
// ==================================================================
// shared constants and carriers of the capture/compare/pwm unit
package ccpu_pkg;

  // ================================================================
  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_PLL     = 8'h04;
  localparam logic [7:0] ADR_PSC     = 8'h08;
  localparam logic [7:0] ADR_TMR     = 8'h0c;
  localparam logic [7:0] ADR_RELOAD  = 8'h10;
  localparam logic [7:0] ADR_CHCTRL  = 8'h14;
  localparam logic [7:0] ADR_CAPCTRL = 8'h18;
  localparam logic [7:0] ADR_FLAGS   = 8'h1c;
  localparam logic [7:0] ADR_IE      = 8'h20;
  localparam logic [7:0] ADR_CMP0    = 8'h24;
  localparam logic [7:0] ADR_CAP0    = 8'h34;
  localparam logic [7:0] ADR_CAP1    = 8'h38;

  // ================================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIR      = 2;
  localparam int CTRL_W8       = 3;
  localparam int CTRL_ALT      = 4;
  localparam int PLL_LOCK_BIT  = 8;
  localparam int CH_POL_LSB    = 4;
  localparam int CH_HALT_LSB   = 8;
  localparam int CH_PIN_LSB    = 12;
  localparam int CAP_FIELD_W   = 8;
  localparam int FLG_OVF       = 0;
  localparam int FLG_CAP0      = 1;
  localparam int FLG_CMP0      = 3;
  localparam int NUM_FLAGS     = 7;

  // ================================================================
  // counts and reset values
  localparam int          PLL_MULT       = 32;
  localparam logic [5:0]  PLL_LOCK_REFS  = 6'(PLL_MULT);
  localparam logic [9:0]  PSC_TOP        = 10'h3ff;
  localparam logic [9:0]  RST_PSC_RELOAD = 10'h3ff;
  localparam logic [15:0] TMR_TOP16      = 16'hffff;
  localparam logic [15:0] TMR_TOP8       = 16'h00ff;
  localparam logic [3:0]  FILT_ALL_HIGH  = 4'hf;
  localparam logic [3:0]  FILT_ALL_LOW   = 4'h0;

  typedef enum logic [1:0] {
    MODE_BASIC = 2'b00,
    MODE_ASYM  = 2'b01,
    MODE_SYM   = 2'b11
  } ccpu_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ccpu_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ccpu_wb_rsp_t;

  typedef struct packed {
    logic [3:0] events;
    logic       filter;
    logic       rising;
  } ccpu_cap_cfg_t;

endpackage

// >>> ccpu_top.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// ==================================================================
module ccpu_top (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ccpu_pkg::ccpu_wb_req_t wb_req,
  output ccpu_pkg::ccpu_wb_rsp_t      wb_rsp,
  input  wire logic [1:0]             cap_in,
  output logic [3:0]                  cmp_out,
  output logic [3:0]                  cmp_oe_n,
  output logic                        irq
);

  // ================================================================
  // state
  ccpu_pkg::ccpu_mode_t    mode_r;
  logic                    dir_down_r;
  logic                    width8_r;
  logic                    alt_r;
  logic [3:0]              pll_divide_value_r;
  logic [3:0]              ref_cnt_r;
  logic [5:0]              lock_cnt_r;
  logic                    pll_lock_r;
  logic [9:0]              psc_reload_r;
  logic [9:0]              psc_cnt_r;
  logic [15:0]             tmr_r;
  logic [15:0]             reload_r;
  logic                    sym_up_r;
  logic                    alt_phase_r;
  logic [3:0]              ch_en_r;
  logic [3:0]              ch_pol_r;
  logic [3:0]              halt_level_bit_r;
  logic [3:0]              out_r;
  logic [3:0]              out_nxt;
  logic [15:0]             cmp_r [4];
  logic [15:0]             cap_r [2];
  ccpu_pkg::ccpu_cap_cfg_t cap_cfg_r [2];
  logic [6:0]              flag_r;
  logic [6:0]              ie_r;
  logic [7:0]              wr_lo_r;
  logic [7:0]              rd_hi_r;
  logic                    ack_r;
  logic [31:0]             rd_r;
  logic [31:0]             rd_mux;

  logic        req;
  logic        wr;
  logic        wr16;
  logic [15:0] w16;
  logic        pll_ref;
  logic        core_tick;
  logic        tick;
  logic [15:0] top;
  logic [15:0] tmr_nxt;
  logic        reload_evt;
  logic        turn;
  logic [3:0]  match;
  logic [3:0]  gate;
  logic [1:0]  cap_evt;
  logic [6:0]  flag_set;
  logic [6:0]  flag_clr;

  // low byte comes from the shadow unless written in the same access
  function automatic logic [15:0] merge16(input logic [3:0] sel, input logic [31:0] dat,
                                          input logic [7:0] lo);
    merge16 = {dat[15:8], (sel[0] ? dat[7:0] : lo)};
  endfunction

  // a lone high-byte read returns the byte latched with the low byte
  function automatic logic [31:0] read16(input logic [3:0] sel, input logic [15:0] v,
                                         input logic [7:0] hi);
    read16 = (sel == 4'b0010) ? {16'h0000, hi, 8'h00} : {16'h0000, v};
  endfunction

  // ================================================================
  // wishbone slave: ack one cycle after the request, write at the ack edge
  assign req  = wb_req.cyc & wb_req.stb;
  assign wr   = req & wb_req.we & ack_r;
  assign wr16 = wr & wb_req.sel[1];
  assign w16  = merge16(wb_req.sel, wb_req.dat, wr_lo_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_req.adr)
      ccpu_pkg::ADR_CTRL:    rd_mux = {27'h0, alt_r, width8_r, dir_down_r, mode_r};
      ccpu_pkg::ADR_PLL:     rd_mux = {23'h0, pll_lock_r, 4'h0, pll_divide_value_r};
      ccpu_pkg::ADR_PSC:     rd_mux = {22'h0, psc_reload_r};
      ccpu_pkg::ADR_TMR:     rd_mux = read16(wb_req.sel, tmr_r, rd_hi_r);
      ccpu_pkg::ADR_RELOAD:  rd_mux = read16(wb_req.sel, reload_r, rd_hi_r);
      ccpu_pkg::ADR_CHCTRL:  rd_mux = {16'h0, out_r, halt_level_bit_r, ch_pol_r, ch_en_r};
      ccpu_pkg::ADR_CAPCTRL: rd_mux = {16'h0, 2'b00, cap_cfg_r[1], 2'b00, cap_cfg_r[0]};
      ccpu_pkg::ADR_FLAGS:   rd_mux = {25'h0, flag_r};
      ccpu_pkg::ADR_IE:      rd_mux = {25'h0, ie_r};
      ccpu_pkg::ADR_CAP0:    rd_mux = read16(wb_req.sel, cap_r[0], rd_hi_r);
      ccpu_pkg::ADR_CAP1:    rd_mux = read16(wb_req.sel, cap_r[1], rd_hi_r);
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (wb_req.adr == ccpu_pkg::ADR_CMP0 + 8'(4 * i)) begin
            rd_mux = read16(wb_req.sel, cmp_r[i], rd_hi_r);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      rd_r <= rd_mux;
    end
  end

  // both byte shadows are shared by all sixteen-bit registers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_lo_r <= 8'h00;
      rd_hi_r <= 8'h00;
    end else begin
      if (wr && wb_req.sel == 4'b0001) begin
        wr_lo_r <= wb_req.dat[7:0];
      end
      if (req && !ack_r && !wb_req.we && wb_req.sel == 4'b0001) begin
        rd_hi_r <= rd_mux[15:8];
      end
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rd_r;

  // ================================================================
  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r     <= ccpu_pkg::MODE_BASIC;
      dir_down_r <= 1'b0;
      width8_r   <= 1'b0;
      alt_r      <= 1'b0;
    end else if (wr && wb_req.adr == ccpu_pkg::ADR_CTRL && wb_req.sel[0]) begin
      case (wb_req.dat[ccpu_pkg::CTRL_MODE_LSB +: 2])
        2'b01:   mode_r <= ccpu_pkg::MODE_ASYM;
        2'b11:   mode_r <= ccpu_pkg::MODE_SYM;
        default: mode_r <= ccpu_pkg::MODE_BASIC;
      endcase
      dir_down_r <= wb_req.dat[ccpu_pkg::CTRL_DIR];
      width8_r   <= wb_req.dat[ccpu_pkg::CTRL_W8];
      alt_r      <= wb_req.dat[ccpu_pkg::CTRL_ALT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pll_divide_value_r <= 4'h0;
      psc_reload_r       <= ccpu_pkg::RST_PSC_RELOAD;
      ie_r               <= 7'h00;
    end else if (wr && wb_req.sel[0]) begin
      if (wb_req.adr == ccpu_pkg::ADR_PLL) begin
        pll_divide_value_r <= wb_req.dat[3:0];
      end
      if (wb_req.adr == ccpu_pkg::ADR_PSC) begin
        psc_reload_r <= {(wb_req.sel[1] ? wb_req.dat[9:8] : psc_reload_r[9:8]), wb_req.dat[7:0]};
      end
      if (wb_req.adr == ccpu_pkg::ADR_IE) begin
        ie_r <= wb_req.dat[6:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch_en_r          <= 4'h0;
      ch_pol_r         <= 4'h0;
      halt_level_bit_r <= 4'h0;
    end else if (wr && wb_req.adr == ccpu_pkg::ADR_CHCTRL) begin
      if (wb_req.sel[0]) begin
        ch_en_r  <= wb_req.dat[3:0];
        ch_pol_r <= wb_req.dat[ccpu_pkg::CH_POL_LSB +: 4];
      end
      if (wb_req.sel[1]) begin
        halt_level_bit_r <= wb_req.dat[ccpu_pkg::CH_HALT_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_cfg_r[0] <= '0;
      cap_cfg_r[1] <= '0;
    end else if (wr && wb_req.adr == ccpu_pkg::ADR_CAPCTRL) begin
      if (wb_req.sel[0]) begin
        cap_cfg_r[0] <= wb_req.dat[5:0];
      end
      if (wb_req.sel[1]) begin
        cap_cfg_r[1] <= wb_req.dat[ccpu_pkg::CAP_FIELD_W +: 6];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_r <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        cmp_r[i] <= 16'h0000;
      end
    end else if (wr16) begin
      if (wb_req.adr == ccpu_pkg::ADR_RELOAD) begin
        reload_r <= w16;
      end
      for (int i = 0; i < 4; i++) begin
        if (wb_req.adr == ccpu_pkg::ADR_CMP0 + 8'(4 * i)) begin
          cmp_r[i] <= w16;
        end
      end
    end
  end

  // ================================================================
  // core clock: the pll is modelled as a lock after 32 reference ticks,
  // after which the core runs on every clk edge (clk is the fastest rate)
  assign pll_ref = (ref_cnt_r == pll_divide_value_r);

  always_ff @(posedge clk) begin
    if (rst || (wr && wb_req.adr == ccpu_pkg::ADR_PLL) || pll_ref) begin
      ref_cnt_r <= 4'h0;
    end else begin
      ref_cnt_r <= ref_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || mode_r == ccpu_pkg::MODE_BASIC || (wr && wb_req.adr == ccpu_pkg::ADR_PLL)) begin
      lock_cnt_r <= 6'h00;
      pll_lock_r <= 1'b0;
    end else if (pll_ref && !pll_lock_r) begin
      lock_cnt_r <= lock_cnt_r + 6'h01;
      if (lock_cnt_r == ccpu_pkg::PLL_LOCK_REFS - 6'h01) begin
        pll_lock_r <= 1'b1;
      end
    end
  end

  assign core_tick = (mode_r == ccpu_pkg::MODE_BASIC) | pll_lock_r;

  // divide ratio is 1024 minus the reload value
  always_ff @(posedge clk) begin
    if (rst) begin
      psc_cnt_r <= ccpu_pkg::RST_PSC_RELOAD;
    end else if (core_tick) begin
      if (psc_cnt_r == ccpu_pkg::PSC_TOP) begin
        psc_cnt_r <= psc_reload_r;
      end else begin
        psc_cnt_r <= psc_cnt_r + 10'h001;
      end
    end
  end

  assign tick = core_tick & (psc_cnt_r == ccpu_pkg::PSC_TOP);

  // ================================================================
  // timer
  assign top = width8_r ? ccpu_pkg::TMR_TOP8 : ccpu_pkg::TMR_TOP16;

  always_comb begin
    tmr_nxt    = tmr_r;
    reload_evt = 1'b0;
    turn       = 1'b0;
    case (mode_r)
      ccpu_pkg::MODE_ASYM: begin
        if (tmr_r == 16'h0000) begin
          tmr_nxt    = reload_r & top;
          reload_evt = 1'b1;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      ccpu_pkg::MODE_SYM: begin
        if (sym_up_r) begin
          if (tmr_r >= (reload_r & top)) begin
            tmr_nxt    = tmr_r - 16'h0001;
            reload_evt = 1'b1;
            turn       = 1'b1;
          end else begin
            tmr_nxt = tmr_r + 16'h0001;
          end
        end else if (tmr_r == 16'h0000) begin
          tmr_nxt = 16'h0001;
          turn    = 1'b1;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      default: begin
        if (!dir_down_r && tmr_r == top) begin
          tmr_nxt    = reload_r & top;
          reload_evt = 1'b1;
        end else if (dir_down_r && tmr_r == 16'h0000) begin
          tmr_nxt    = reload_r & top;
          reload_evt = 1'b1;
        end else if (dir_down_r) begin
          tmr_nxt = tmr_r - 16'h0001;
        end else begin
          tmr_nxt = tmr_r + 16'h0001;
        end
      end
    endcase
  end

  // a software write wins over the count in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_r <= 16'h0000;
    end else if (wr16 && wb_req.adr == ccpu_pkg::ADR_TMR) begin
      tmr_r <= w16 & top;
    end else if (tick) begin
      tmr_r <= tmr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || mode_r != ccpu_pkg::MODE_SYM) begin
      sym_up_r <= 1'b1;
    end else if (tick && turn) begin
      sym_up_r <= ~sym_up_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || mode_r != ccpu_pkg::MODE_ASYM || !alt_r) begin
      alt_phase_r <= 1'b0;
    end else if (tick && reload_evt) begin
      alt_phase_r <= ~alt_phase_r;
    end
  end

  // ================================================================
  // compare channels; out_r is the pin level before the alternate gate, pol=1 means active low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i]   = tick & ch_en_r[i] & (tmr_r == cmp_r[i]);
      out_nxt[i] = out_r[i];
      if (!ch_en_r[i]) begin
        out_nxt[i] = halt_level_bit_r[i];
      end else begin
        case (mode_r)
          ccpu_pkg::MODE_ASYM: begin
            if (match[i]) begin
              out_nxt[i] = ch_pol_r[i];
            end else if (tick && reload_evt) begin
              out_nxt[i] = ~ch_pol_r[i];
            end
          end
          ccpu_pkg::MODE_SYM: begin
            if (match[i]) begin
              out_nxt[i] = sym_up_r ? ch_pol_r[i] : ~ch_pol_r[i];
            end
          end
          default: begin
            if (match[i]) begin
              out_nxt[i] = ~out_r[i];
            end
          end
        endcase
      end
      gate[i] = !(alt_r && mode_r == ccpu_pkg::MODE_ASYM) || (alt_phase_r == i[0]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_r   <= 4'h0;
      cmp_out <= 4'h0;
    end else begin
      out_r <= out_nxt;
      for (int i = 0; i < 4; i++) begin
        cmp_out[i] <= (gate[i] || !ch_en_r[i]) ? out_nxt[i] : ch_pol_r[i];
      end
    end
  end

  assign cmp_oe_n = ~ch_en_r;

  // ================================================================
  // capture inputs
  for (genvar j = 0; j < 2; j++) begin : g_cap
    ccpu_capture u_cap (
      .clk     (clk),
      .rst     (rst),
      .cap_pin (cap_in[j]),
      .cfg     (cap_cfg_r[j]),
      .event_p (cap_evt[j])
    );
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_r[0] <= 16'h0000;
      cap_r[1] <= 16'h0000;
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (cap_evt[j]) begin
          cap_r[j] <= tmr_r;
        end
      end
    end
  end

  // ================================================================
  // flags: write one to clear, a new event wins over the clear
  assign flag_set = {match, cap_evt, tick & reload_evt};
  assign flag_clr = (wr && wb_req.adr == ccpu_pkg::ADR_FLAGS && wb_req.sel[0]) ? wb_req.dat[6:0] : 7'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 7'h00;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  assign irq = |(flag_r & ie_r);

endmodule

// >>> ccpu_top_checker.sv
`timescale 1ns/1ps
// ==================================================================
// port relations of the unit: bus handshake, pin enables, request line
module ccpu_top_checker (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire ccpu_pkg::ccpu_wb_req_t wb_req,
  input wire ccpu_pkg::ccpu_wb_rsp_t wb_rsp,
  input wire logic [1:0]             cap_in,
  input wire logic [3:0]             cmp_out,
  input wire logic [3:0]             cmp_oe_n,
  input wire logic                   irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_ack_gone;
    wb_rsp.ack ##1 !wb_rsp.ack;
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_rsp.ack) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_rsp.ack |-> s_ack_gone) else $error("ack too long");
  a_ack_has_cause: assert property (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst) |-> !wb_rsp.ack && cmp_oe_n == 4'hf && cmp_out == 4'h0 && !irq)
    else $error("outputs not quiet after reset");
  a_enable_by_write: assert property (!$stable(cmp_oe_n) |-> $past(wb_rsp.ack && wb_req.we))
    else $error("pin enable moved without a write");
  a_idle_pins_hold: assert property (cmp_oe_n == 4'hf && $past(cmp_oe_n) == 4'hf
    && !$past(wb_rsp.ack && wb_req.we) && !$past(wb_rsp.ack && wb_req.we, 2)
    |-> $stable(cmp_out)) else $error("idle pin moved");
  // connecting a pin must not disturb the level it already shows
  a_connect_keeps: assert property (($past(cmp_oe_n) & ~cmp_oe_n) != 4'h0
    |-> (($past(cmp_oe_n) & ~cmp_oe_n) & (cmp_out ^ $past(cmp_out))) == 4'h0)
    else $error("pin jumped when connected");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wb_rsp.ack && wb_req.we)
    || $past(wb_rsp.ack && wb_req.we, 2)) else $error("request dropped by itself");
  a_unmapped_zero: assert property (wb_rsp.ack && !wb_req.we && wb_req.adr > 8'h38 |-> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind ccpu_top ccpu_top_checker ccpu_top_checker_inst (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .cap_in(cap_in), .cmp_out(cmp_out), .cmp_oe_n(cmp_oe_n), .irq(irq));

// >>> ccpu_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
// ==================================================================
// directed bench of the capture/compare/pwm unit
module ccpu_top_tb_top;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  ccpu_pkg::ccpu_wb_req_t wb_req = '0;
  ccpu_pkg::ccpu_wb_rsp_t wb_rsp;
  logic [1:0]             cap_in;
  logic [1:0]             lvl = 2'h0;
  logic [3:0]             cmp_out;
  logic [3:0]             cmp_oe_n;
  logic [3:0]             pin_seen;
  logic                   irq;
  logic [31:0]            rd;
  logic [15:0]            a;
  int                     err_total = 0;
  int                     check_count = 0;
  int                     cyc_n = 0;

  always #2.5 clk = ~clk;
  ccpu_top ccpu_top_inst (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .cap_in(cap_in),
    .cmp_out(cmp_out), .cmp_oe_n(cmp_oe_n), .irq(irq));
  ccpu_pins_model ccpu_pins_model_inst (.clk(clk), .lvl(lvl), .cmp_out(cmp_out), .cmp_oe_n(cmp_oe_n),
    .cap_in(cap_in), .pin_seen(pin_seen));

  // ================================================================
  // bus access and helpers
  task close_out;
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      close_out();
    end
  end
  task wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    @(posedge clk);
    while (wb_rsp.ack !== 1'b1) begin
      @(posedge clk);
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d); wb_acc(1'b1, ad, d); endtask
  task rdr(input logic [7:0] ad); wb_acc(1'b0, ad, 32'h0); endtask
  task wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK("irq", v, irq)
  endtask

  // ================================================================
  // scenarios
  task t_reset;
    rdr(ccpu_pkg::ADR_PSC); `CHK("psc reload", ccpu_pkg::RST_PSC_RELOAD, rd[9:0])
    wr(8'h3c, 32'hffffffff);
    rdr(8'h3c); `CHK("unmapped", 32'h0, rd)
    `CHK("oe idle", 4'hf, cmp_oe_n)
  endtask
  task t_overflow;
    wr(ccpu_pkg::ADR_IE, 32'h1);
    wr(ccpu_pkg::ADR_RELOAD, 32'hfff0);
    wr(ccpu_pkg::ADR_FLAGS, 32'h7f);
    wr(ccpu_pkg::ADR_TMR, 32'hfffa);
    wait_irq(1'b1);
    rdr(ccpu_pkg::ADR_TMR); `CHK("reloaded", 12'hfff, rd[15:4])
    wr(ccpu_pkg::ADR_TMR, 32'h0);
    wr(ccpu_pkg::ADR_FLAGS, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  // three cycles separate two reads, so the count moves by three ticks
  task t_dir_psc;
    wr(ccpu_pkg::ADR_CTRL, 32'h4);
    wr(ccpu_pkg::ADR_TMR, 32'h0100);
    rdr(ccpu_pkg::ADR_TMR); a = rd[15:0];
    rdr(ccpu_pkg::ADR_TMR); `CHK("down", a - 16'd3, rd[15:0])
    wr(ccpu_pkg::ADR_PSC, 32'h3fd);
    rdr(ccpu_pkg::ADR_TMR); a = rd[15:0];
    rdr(ccpu_pkg::ADR_TMR); `CHK("div3", a - 16'd1, rd[15:0])
    wr(ccpu_pkg::ADR_PSC, 32'h3ff);
  endtask
  task t_w8;
    wr(ccpu_pkg::ADR_CTRL, 32'h8);
    wr(ccpu_pkg::ADR_RELOAD, 32'h0);
    wr(ccpu_pkg::ADR_TMR, 32'h00f0);
    wr(ccpu_pkg::ADR_FLAGS, 32'h7f);
    wait_irq(1'b1);
    rdr(ccpu_pkg::ADR_TMR); `CHK("w8 high", 8'h00, rd[15:8])
    wr(ccpu_pkg::ADR_IE, 32'h0);
  endtask
  task t_compare;
    wr(ccpu_pkg::ADR_CTRL, 32'h0);
    wr(ccpu_pkg::ADR_TMR, 32'h0);
    wr(ccpu_pkg::ADR_CMP0, 32'h0040);
    wr(ccpu_pkg::ADR_CHCTRL, 32'h1);
    `CHK("oe a", 4'he, cmp_oe_n)
    wr(ccpu_pkg::ADR_FLAGS, 32'h7f);
    wr(ccpu_pkg::ADR_IE, 32'h8);
    wait_irq(1'b1);
    `CHK("pin a", 4'h1, pin_seen)
    wr(ccpu_pkg::ADR_IE, 32'h0);
  endtask
  task t_capture;
    wr(ccpu_pkg::ADR_CAPCTRL, 32'h0201);
    lvl <= 2'b10;
    repeat (10) @(posedge clk);
    wr(ccpu_pkg::ADR_FLAGS, 32'h7f);
    wr(ccpu_pkg::ADR_TMR, 32'h1000);
    lvl <= 2'b11;
    repeat (10) @(posedge clk);
    rdr(ccpu_pkg::ADR_FLAGS); `CHK("cap0 flag", 1'b1, rd[1])
    rdr(ccpu_pkg::ADR_CAP0); `CHK("cap0 value", 8'h10, rd[15:8])
    lvl <= 2'b01;
    repeat (2) @(posedge clk);
    lvl <= 2'b11;
    repeat (10) @(posedge clk);
    rdr(ccpu_pkg::ADR_FLAGS); `CHK("glitch", 1'b0, rd[2])
    lvl <= 2'b01;
    repeat (12) @(posedge clk);
    rdr(ccpu_pkg::ADR_FLAGS); `CHK("cap1 flag", 1'b1, rd[2])
    wr(ccpu_pkg::ADR_CAPCTRL, 32'h0205);
    wr(ccpu_pkg::ADR_FLAGS, 32'h7f);
    lvl <= 2'b00;
    repeat (6) @(posedge clk);
    lvl <= 2'b01;
    repeat (6) @(posedge clk);
    rdr(ccpu_pkg::ADR_FLAGS); `CHK("first edge held", 1'b0, rd[1])
    lvl <= 2'b00;
    repeat (6) @(posedge clk);
    lvl <= 2'b01;
    repeat (6) @(posedge clk);
    rdr(ccpu_pkg::ADR_FLAGS); `CHK("second edge", 1'b1, rd[1])
  endtask
  task t_pll_asym;
    wr(ccpu_pkg::ADR_CTRL, 32'h1);
    wr(ccpu_pkg::ADR_PLL, 32'h1);
    // n=1 locks after 64 cycles; an undivided reference would lock after 32
    repeat (45) @(posedge clk);
    rdr(ccpu_pkg::ADR_PLL); `CHK("lock early", 1'b0, rd[ccpu_pkg::PLL_LOCK_BIT])
    repeat (30) @(posedge clk);
    rdr(ccpu_pkg::ADR_PLL); `CHK("lock", 1'b1, rd[ccpu_pkg::PLL_LOCK_BIT])
    wr(ccpu_pkg::ADR_TMR, 32'h0100);
    rdr(ccpu_pkg::ADR_TMR); a = rd[15:0];
    rdr(ccpu_pkg::ADR_TMR); `CHK("asym down", a - 16'd3, rd[15:0])
  endtask
  // channel a active low: match drives it high, reload low
  task t_pwm;
    wr(ccpu_pkg::ADR_RELOAD, 32'h0080);
    wr(ccpu_pkg::ADR_CHCTRL, 32'h11);
    wr(ccpu_pkg::ADR_TMR, 32'h0050);
    repeat (20) @(posedge clk);
    `CHK("pol match", 1'b1, pin_seen[0])
    repeat (64) @(posedge clk);
    `CHK("pol reload", 1'b0, pin_seen[0])
    wr(ccpu_pkg::ADR_CMP0 + 8'h04, 32'h0040);
    wr(ccpu_pkg::ADR_CHCTRL, 32'h03);
    wr(ccpu_pkg::ADR_CTRL, 32'h11);
    wr(ccpu_pkg::ADR_TMR, 32'h0005);
    repeat (10) @(posedge clk);
    `CHK("alt b", 2'b10, pin_seen[1:0])
    repeat (130) @(posedge clk);
    `CHK("alt a", 2'b01, pin_seen[1:0])
    wr(ccpu_pkg::ADR_CTRL, 32'h3);
    wr(ccpu_pkg::ADR_TMR, 32'h0010);
    rdr(ccpu_pkg::ADR_TMR); a = rd[15:0];
    rdr(ccpu_pkg::ADR_TMR); `CHK("sym up", a + 16'd3, rd[15:0])
    repeat (150) @(posedge clk);
    rdr(ccpu_pkg::ADR_TMR); a = rd[15:0];
    rdr(ccpu_pkg::ADR_TMR); `CHK("sym down", a - 16'd3, rd[15:0])
  endtask
  task t_rst;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("rst oe", 4'hf, cmp_oe_n)
    `CHK("rst pins", 4'h0, cmp_out)
    rdr(ccpu_pkg::ADR_CTRL); `CHK("rst mode", 32'h0, rd)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_overflow();
    t_dir_psc();
    t_w8();
    t_compare();
    t_capture();
    t_pll_asym();
    t_pwm();
    t_rst();
    close_out();
  end
endmodule
